/* File: include/sct_pkg.sv */
// Package: register map, field layout, structs and constants for the conversion timing block
package sct_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Register word addresses
    localparam logic [ADDR_W-1:0] REG_GEN_ENABLE  = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CLK1_DIV    = 4'h1;
    localparam logic [ADDR_W-1:0] REG_CLK2_DIV    = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CLK_SRC     = 4'h3;
    localparam logic [ADDR_W-1:0] REG_FRAME_CFG   = 4'h4;
    localparam logic [ADDR_W-1:0] REG_FRAME_CNT   = 4'h5;
    localparam logic [ADDR_W-1:0] REG_ROUTE       = 4'h6;
    localparam logic [ADDR_W-1:0] REG_AD_SEQ      = 4'h7;
    localparam logic [ADDR_W-1:0] REG_DA_SEQ      = 4'h8;
    localparam logic [ADDR_W-1:0] REG_STATUS      = 4'h9;
    localparam logic [ADDR_W-1:0] REG_ADC_CFG     = 4'ha;

    // REG_GEN_ENABLE bits
    localparam int EN_CLK1  = 0;
    localparam int EN_CLK2  = 1;
    localparam int EN_FRAME = 2;
    // REG_CLK_SRC bits
    localparam int SRC_CLK1_REF = 0;
    localparam int SRC_CLK2_REF = 1;
    localparam int SRC_FRAME_ASSOC = 2;
    // REG_FRAME_CFG: [15:0] interval, bit 16 continuous
    localparam int FRAME_CONT = 16;
    // REG_ROUTE: per signal (0 clk1, 1 clk2, 2 frame) internal sel, front oe, rear oe, pin sel
    localparam int ROUTE_INT   = 0;
    localparam int ROUTE_FRONT = 3;
    localparam int ROUTE_REAR  = 6;
    localparam int ROUTE_PIN   = 9;
    // Sequencer cfg: [15:0] count, 16 clock select, 17 frame mode, 18 enable
    localparam int SEQ_CLK_SEL = 16;
    localparam int SEQ_FRAME   = 17;
    localparam int SEQ_ENABLE  = 18;
    // Status bits (frame error flags write one to clear; active and busy bits are live)
    localparam int ST_AD_ACT = 0;
    localparam int ST_DA_ACT = 1;
    localparam int ST_AD_FERR = 2;
    localparam int ST_DA_FERR = 3;
    localparam int ST_FRAME_BUSY = 4;

    localparam int CNT_W = 16;
    localparam int NUM_ADC = 4;
    localparam int CH_W = 3;

    localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DIV_RESET  = 32'h0000_0001;

    // Three control lines: one bit each
    typedef struct packed {
        logic frame;
        logic clk2;
        logic clk1;
    } sct_lines_t;

    // Shared A/D sample strobe bundle, one mask bit per converter
    typedef struct packed {
        logic [NUM_ADC-1:0] adc_mask;
        logic [CH_W-1:0]    channel;
        logic               strobe;
        logic               last;
    } sct_sample_t;

endpackage : sct_pkg

/* File: hdl/sct_clk_gen.sv */
// Conversion clock generator: reference select and divider
`timescale 1ns/1ns
module sct_clk_gen #(
    parameter int DIV_W = 16
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             enable_i,
    input  wire logic             ref_sel_i,
    input  wire logic             ref_a_i,
    input  wire logic             ref_b_i,
    input  wire logic [DIV_W-1:0] half_period_i,
    output logic                  clk_o,
    output logic                  rise_o
);
    import sct_pkg::*;

    logic [DIV_W-1:0] count_r;
    logic             ref_tick;

    // Reference ticks are one-cycle enables from the core clock
    assign ref_tick = ref_sel_i ? ref_b_i : ref_a_i;

    // Free-running toggle while enabled, no start condition
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !enable_i) begin
            count_r <= '0;
            clk_o   <= 1'b0;
            rise_o  <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            if (ref_tick) begin
                if (count_r + DIV_W'(1) >= half_period_i) begin
                    count_r <= '0;
                    clk_o   <= ~clk_o;
                    rise_o  <= ~clk_o;
                end else begin
                    count_r <= count_r + DIV_W'(1);
                end
            end
        end
    end

endmodule : sct_clk_gen

/* File: hdl/sct_seq_ctl.sv */
// Sequencer pacing: normal or frame mode burst control with frame error
`timescale 1ns/1ns
module sct_seq_ctl #(
    parameter int CW = 16
) (
    input  wire logic          clk_i,
    input  wire logic          reset_n_i,
    input  wire logic          enable_i,
    input  wire logic          frame_mode_i,
    input  wire logic [CW-1:0] count_i,
    input  wire logic          conv_evt_i,
    input  wire logic          frame_evt_i,
    output logic               pulse_o,
    output logic               active_o,
    output logic               frame_err_o
);
    import sct_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_STOP} sct_seq_st_t;
    sct_seq_st_t state_r;
    logic [CW-1:0] done_r;
    logic          cont;

    assign cont = (count_i == '0);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !enable_i) begin
            state_r     <= ST_IDLE;
            done_r      <= '0;
            pulse_o     <= 1'b0;
            frame_err_o <= 1'b0;
        end else begin
            pulse_o     <= 1'b0;
            frame_err_o <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    // Frame mode waits for a trigger; normal mode starts on enable
                    if (!frame_mode_i || frame_evt_i) begin
                        state_r <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (conv_evt_i) begin
                        state_r <= ST_RUN;
                        pulse_o <= 1'b1;
                        done_r  <= CW'(1);
                        if (!cont && count_i == CW'(1)) begin
                            state_r <= frame_mode_i ? ST_IDLE : ST_STOP;
                        end
                    end
                end
                ST_RUN: begin
                    if (frame_mode_i && frame_evt_i && !cont) begin
                        frame_err_o <= 1'b1;
                        state_r     <= ST_STOP;
                    end else if (conv_evt_i) begin
                        pulse_o <= 1'b1;
                        done_r  <= done_r + CW'(1);
                        if (!cont && done_r + CW'(1) == count_i) begin
                            state_r <= frame_mode_i ? ST_IDLE : ST_STOP;
                        end
                    end
                end
                ST_STOP: state_r <= ST_STOP;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign active_o = (state_r == ST_RUN);

endmodule : sct_seq_ctl

/* File: hdl/sct_timing.sv */
// Sequencer conversion timing: clock generators, frame trigger, routing, sequencer pacing
`timescale 1ns/1ns
module sct_timing #(
    parameter int DIV_W = 16
) (
    input  wire logic                      clk_i,
    input  wire logic                      reset_n_i,
    // Avalon-MM slave
    input  wire logic [sct_pkg::ADDR_W-1:0] avs_address_i,
    input  wire logic                      avs_read_i,
    input  wire logic                      avs_write_i,
    input  wire logic [sct_pkg::DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]                avs_byteenable_i,
    output logic [sct_pkg::DATA_W-1:0]     avs_readdata_o,
    output logic                           avs_waitrequest_o,
    // Reference clock ticks
    input  wire logic                      ref_a_tick_i,
    input  wire logic                      ref_b_tick_i,
    // Control pins: receivers, front and rear
    input  wire sct_pkg::sct_lines_t       front_in_i,
    input  wire sct_pkg::sct_lines_t       rear_in_i,
    output sct_pkg::sct_lines_t            front_out_o,
    output sct_pkg::sct_lines_t            front_oe_o,
    output sct_pkg::sct_lines_t            rear_out_o,
    output sct_pkg::sct_lines_t            rear_oe_o,
    // Converter pacing
    output logic                           dac_pulse_o,
    output sct_pkg::sct_sample_t           adc_sample_o
);
    import sct_pkg::*;

    logic [DATA_W-1:0] en_r, div1_r, div2_r, src_r, fcfg_r, fcnt_r, route_r;
    logic [DATA_W-1:0] adseq_r, daseq_r, adccfg_r;
    logic [4:0]        status_r;
    sct_lines_t        gen_out, pin_in, sel_line, sel_prev_r;
    logic              clk1_out, clk2_out, clk1_rise, clk2_rise;
    logic              assoc_rise, assoc_prev_r;

    // Frame trigger generator state
    logic [CNT_W-1:0] fint_cnt_r, fpulses_r;
    logic             frame_out_r, frame_run_r;

    // Sequencer events
    logic ad_evt, da_evt, frame_evt;
    logic ad_pulse, da_pulse, ad_act, da_act, ad_ferr, da_ferr;

    // Avalon slave: waitrequest idles high, drops for one cycle per request
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
        end
    end

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                                input logic [DATA_W-1:0] new_v,
                                                input logic [3:0]        be);
        logic [DATA_W-1:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return r;
    endfunction : merge

    logic wr_stb;
    assign wr_stb = avs_write_i && !avs_waitrequest_o;

    // Configuration registers; reset leaves drivers off and pins as sources
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            en_r     <= RESET_WORD;
            div1_r   <= DIV_RESET;
            div2_r   <= DIV_RESET;
            src_r    <= RESET_WORD;
            fcfg_r   <= DIV_RESET;
            fcnt_r   <= RESET_WORD;
            route_r  <= RESET_WORD;
            adseq_r  <= RESET_WORD;
            daseq_r  <= RESET_WORD;
            adccfg_r <= RESET_WORD;
        end else if (wr_stb) begin
            case (avs_address_i)
                REG_GEN_ENABLE: en_r   <= merge(en_r, avs_writedata_i, avs_byteenable_i);
                REG_CLK1_DIV:   div1_r <= merge(div1_r, avs_writedata_i, avs_byteenable_i);
                REG_CLK2_DIV:   div2_r <= merge(div2_r, avs_writedata_i, avs_byteenable_i);
                REG_CLK_SRC:    src_r  <= merge(src_r, avs_writedata_i, avs_byteenable_i);
                REG_FRAME_CFG:  fcfg_r <= merge(fcfg_r, avs_writedata_i, avs_byteenable_i);
                REG_FRAME_CNT:  fcnt_r <= merge(fcnt_r, avs_writedata_i, avs_byteenable_i);
                REG_ROUTE:      route_r <= merge(route_r, avs_writedata_i, avs_byteenable_i);
                REG_AD_SEQ:     adseq_r <= merge(adseq_r, avs_writedata_i, avs_byteenable_i);
                REG_DA_SEQ:     daseq_r <= merge(daseq_r, avs_writedata_i, avs_byteenable_i);
                REG_ADC_CFG:    adccfg_r <= merge(adccfg_r, avs_writedata_i, avs_byteenable_i);
                default: ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && avs_waitrequest_o) begin
            case (avs_address_i)
                REG_GEN_ENABLE: avs_readdata_o <= en_r;
                REG_CLK1_DIV:   avs_readdata_o <= div1_r;
                REG_CLK2_DIV:   avs_readdata_o <= div2_r;
                REG_CLK_SRC:    avs_readdata_o <= src_r;
                REG_FRAME_CFG:  avs_readdata_o <= fcfg_r;
                REG_FRAME_CNT:  avs_readdata_o <= fcnt_r;
                REG_ROUTE:      avs_readdata_o <= route_r;
                REG_AD_SEQ:     avs_readdata_o <= adseq_r;
                REG_DA_SEQ:     avs_readdata_o <= daseq_r;
                REG_STATUS:     avs_readdata_o <= {27'h0, status_r};
                REG_ADC_CFG:    avs_readdata_o <= adccfg_r;
                default:        avs_readdata_o <= '0;
            endcase
        end
    end

    // Both generators share one enable register so one write starts both
    sct_clk_gen #(.DIV_W(DIV_W)) u_clk1 (
        .clk_i         (clk_i),
        .reset_n_i     (reset_n_i),
        .enable_i      (en_r[EN_CLK1]),
        .ref_sel_i     (src_r[SRC_CLK1_REF]),
        .ref_a_i       (ref_a_tick_i),
        .ref_b_i       (ref_b_tick_i),
        .half_period_i (div1_r[DIV_W-1:0]),
        .clk_o         (clk1_out),
        .rise_o        (clk1_rise)
    );

    sct_clk_gen #(.DIV_W(DIV_W)) u_clk2 (
        .clk_i         (clk_i),
        .reset_n_i     (reset_n_i),
        .enable_i      (en_r[EN_CLK2]),
        .ref_sel_i     (src_r[SRC_CLK2_REF]),
        .ref_a_i       (ref_a_tick_i),
        .ref_b_i       (ref_b_tick_i),
        .half_period_i (div2_r[DIV_W-1:0]),
        .clk_o         (clk2_out),
        .rise_o        (clk2_rise)
    );

    assign assoc_rise = src_r[SRC_FRAME_ASSOC] ? clk2_rise : clk1_rise;

    // Frame trigger: low for one associated period every interval cycles
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !en_r[EN_FRAME]) begin
            fint_cnt_r  <= '0;
            fpulses_r   <= '0;
            frame_out_r <= 1'b1;
            // Re-armed while off so the enabling write starts the train
            frame_run_r <= 1'b1;
            assoc_prev_r <= 1'b0;
        end else begin
            assoc_prev_r <= assoc_rise;
            if (assoc_rise && frame_run_r) begin
                if (fint_cnt_r == '0) begin
                    frame_out_r <= 1'b0;
                    fpulses_r   <= fpulses_r + CNT_W'(1);
                end else begin
                    frame_out_r <= 1'b1;
                end
                if (fint_cnt_r + CNT_W'(1) >= fcfg_r[CNT_W-1:0]) begin
                    fint_cnt_r <= '0;
                    if (!fcfg_r[FRAME_CONT] && fpulses_r + CNT_W'(1) >= fcnt_r[CNT_W-1:0]
                        && fint_cnt_r == '0 && fcfg_r[CNT_W-1:0] <= CNT_W'(1)) begin
                        frame_run_r <= 1'b0;
                    end
                end else begin
                    fint_cnt_r <= fint_cnt_r + CNT_W'(1);
                end
            end else if (assoc_rise) begin
                frame_out_r <= 1'b1;
            end
            // Counted mode stops after last pulse has ended
            if (!fcfg_r[FRAME_CONT] && fpulses_r >= fcnt_r[CNT_W-1:0] && fcnt_r != '0
                && assoc_rise && frame_out_r == 1'b0) begin
                frame_run_r <= 1'b0;
            end
        end
    end

    assign gen_out = '{frame: frame_out_r, clk2: clk2_out, clk1: clk1_out};

    // Receivers always live; pin choice is front or rear per signal
    for (genvar i = 0; i < 3; i++) begin : g_line
        always_comb begin
            pin_in[i]   = route_r[ROUTE_PIN+i] ? rear_in_i[i] : front_in_i[i];
            sel_line[i] = route_r[ROUTE_INT+i] ? gen_out[i] : pin_in[i];
        end
        always_ff @(posedge clk_i) begin
            if (!reset_n_i) begin
                front_oe_o[i]  <= 1'b0;
                rear_oe_o[i]   <= 1'b0;
                front_out_o[i] <= 1'b0;
                rear_out_o[i]  <= 1'b0;
                sel_prev_r[i]  <= 1'b0;
            end else begin
                front_oe_o[i]  <= route_r[ROUTE_FRONT+i];
                rear_oe_o[i]   <= route_r[ROUTE_REAR+i];
                front_out_o[i] <= gen_out[i];
                rear_out_o[i]  <= gen_out[i];
                sel_prev_r[i]  <= sel_line[i];
            end
        end
    end

    // Events: clock rising edge, frame trigger falling edge
    assign ad_evt = adseq_r[SEQ_CLK_SEL] ? (sel_line.clk2 && !sel_prev_r.clk2)
                                         : (sel_line.clk1 && !sel_prev_r.clk1);
    assign da_evt = daseq_r[SEQ_CLK_SEL] ? (sel_line.clk2 && !sel_prev_r.clk2)
                                         : (sel_line.clk1 && !sel_prev_r.clk1);
    assign frame_evt = !sel_line.frame && sel_prev_r.frame;

    sct_seq_ctl #(.CW(CNT_W)) u_ad_seq (
        .clk_i        (clk_i),
        .reset_n_i    (reset_n_i),
        .enable_i     (adseq_r[SEQ_ENABLE]),
        .frame_mode_i (adseq_r[SEQ_FRAME]),
        .count_i      (adseq_r[CNT_W-1:0]),
        .conv_evt_i   (ad_evt),
        .frame_evt_i  (frame_evt),
        .pulse_o      (ad_pulse),
        .active_o     (ad_act),
        .frame_err_o  (ad_ferr)
    );

    sct_seq_ctl #(.CW(CNT_W)) u_da_seq (
        .clk_i        (clk_i),
        .reset_n_i    (reset_n_i),
        .enable_i     (daseq_r[SEQ_ENABLE]),
        .frame_mode_i (daseq_r[SEQ_FRAME]),
        .count_i      (daseq_r[CNT_W-1:0]),
        .conv_evt_i   (da_evt),
        .frame_evt_i  (frame_evt),
        .pulse_o      (da_pulse),
        .active_o     (da_act),
        .frame_err_o  (da_ferr)
    );

    // Status: error flags sticky, set wins over write-one-to-clear
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            status_r <= '0;
        end else begin
            status_r[ST_AD_ACT]     <= ad_act;
            status_r[ST_DA_ACT]     <= da_act;
            status_r[ST_FRAME_BUSY] <= frame_run_r && en_r[EN_FRAME];
            status_r[ST_AD_FERR] <= ad_ferr ||
                (status_r[ST_AD_FERR] && !(wr_stb && avs_address_i == REG_STATUS
                                           && avs_writedata_i[ST_AD_FERR]));
            status_r[ST_DA_FERR] <= da_ferr ||
                (status_r[ST_DA_FERR] && !(wr_stb && avs_address_i == REG_STATUS
                                           && avs_writedata_i[ST_DA_FERR]));
        end
    end

    // D/A: one shared pulse to all DACs
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            dac_pulse_o <= 1'b0;
        end else begin
            dac_pulse_o <= da_pulse;
        end
    end

    // A/D: walk channels 0..max ascending, all sequencer-mode ADCs in parallel
    logic [CH_W-1:0] ch_r, last_ch;
    logic            walk_r;
    assign last_ch = adccfg_r[NUM_ADC +: CH_W];

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ch_r         <= '0;
            walk_r       <= 1'b0;
            adc_sample_o <= '0;
        end else begin
            adc_sample_o.strobe <= 1'b0;
            adc_sample_o.last   <= 1'b0;
            if (ad_pulse && !walk_r) begin
                walk_r <= 1'b1;
                ch_r   <= '0;
            end else if (walk_r) begin
                adc_sample_o.strobe   <= 1'b1;
                adc_sample_o.channel  <= ch_r;
                adc_sample_o.adc_mask <= adccfg_r[NUM_ADC-1:0];
                adc_sample_o.last     <= (ch_r == last_ch);
                if (ch_r == last_ch) begin
                    walk_r <= 1'b0;
                end else begin
                    ch_r <= ch_r + CH_W'(1);
                end
            end
        end
    end

endmodule : sct_timing

/* File: dv/sct_timing_sva.sv */
// Checker: bus handshake, reset state and converter pacing
`timescale 1ns/1ns
module sct_timing_sva (
    input wire logic                clk_i,
    input wire logic                reset_n_i,
    input wire logic                avs_read_i,
    input wire logic                avs_write_i,
    input wire logic                avs_waitrequest_o,
    input wire sct_pkg::sct_lines_t  front_oe_o,
    input wire sct_pkg::sct_lines_t  rear_oe_o,
    input wire logic                dac_pulse_o,
    input wire sct_pkg::sct_sample_t adc_sample_o
);
    import sct_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wait_first_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("no wait cycle");
    wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("wait too long");
    reset_oe_a: assert property ($rose(reset_n_i) |-> front_oe_o == '0 && rear_oe_o == '0)
        else $error("driver on after reset");
    reset_quiet_a: assert property ($rose(reset_n_i) |-> !dac_pulse_o && !adc_sample_o.strobe)
        else $error("pacing after reset");
    dac_single_a: assert property (dac_pulse_o |=> !dac_pulse_o) else $error("dac pulse wide");
    ch_start_a: assert property ($rose(adc_sample_o.strobe) |-> adc_sample_o.channel == '0)
        else $error("burst not at channel 0");
    ch_step_a: assert property (adc_sample_o.strobe && !adc_sample_o.last |=>
        adc_sample_o.strobe && adc_sample_o.channel == $past(adc_sample_o.channel) + 3'h1)
        else $error("channel order");
    mask_hold_a: assert property (adc_sample_o.strobe && !adc_sample_o.last |=>
        $stable(adc_sample_o.adc_mask)) else $error("mask moved in burst");
endmodule : sct_timing_sva
bind sct_timing sct_timing_sva u_sva (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .front_oe_o(front_oe_o), .rear_oe_o(rear_oe_o), .dac_pulse_o(dac_pulse_o),
    .adc_sample_o(adc_sample_o));

/* File: dv/sct_pin_model.sv */
// Far side of the control pins: other cards and loose lines
`timescale 1ns/1ns
module sct_pin_model (
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    input  wire sct_pkg::sct_lines_t front_out_i,
    input  wire sct_pkg::sct_lines_t front_oe_i,
    input  wire sct_pkg::sct_lines_t rear_out_i,
    input  wire sct_pkg::sct_lines_t rear_oe_i,
    output sct_pkg::sct_lines_t      front_in_o,
    output sct_pkg::sct_lines_t      rear_in_o
);
    import sct_pkg::*;
    logic [3:0] ph_r;
    logic       tog_r;
    logic [2:0] ext;
    always_ff @(posedge clk_i) begin
        ph_r  <= reset_n_i ? ph_r + 4'h1 : 4'h0;
        tog_r <= reset_n_i ? !tog_r : 1'b0;
    end
    // Master card: frame is one inverted clk1 period every four periods
    assign ext = {!(ph_r[3:2] == 2'b11), ph_r[2], ph_r[1]};
    // Own driver level feeds back; loose front lines wander
    assign rear_in_o  = (rear_oe_i & rear_out_i) | (~rear_oe_i & ext);
    assign front_in_o = (front_oe_i & front_out_i) | (~front_oe_i & {3{tog_r}});
endmodule : sct_pin_model

/* File: dv/sct_timing_tb.sv */
// Bench: registers, clock routing, frame pulses and converter pacing
`timescale 1ns/1ns
module sct_timing_tb;
    import sct_pkg::*;
    logic clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic ref_a_tick_i, ref_b_tick_i, dac_pulse_o, prev_f;
    logic [ADDR_W-1:0] avs_address_i;
    logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o, q, d;
    logic [3:0]        avs_byteenable_i;
    sct_lines_t  front_in_i, rear_in_i, front_out_o, front_oe_o, rear_out_o, rear_oe_o;
    sct_sample_t adc_sample_o;
    int err_count, n_compared, n_dac, n_str, n_bad, n_fall, low_cnt, low_len, p1, p2;
    sct_timing uut (.clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .ref_a_tick_i, .ref_b_tick_i, .front_in_i, .rear_in_i, .front_out_o, .front_oe_o,
        .rear_out_o, .rear_oe_o, .dac_pulse_o, .adc_sample_o);
    sct_pin_model pm (.clk_i, .reset_n_i, .front_out_i(front_out_o), .front_oe_i(front_oe_o),
        .rear_out_i(rear_out_o), .rear_oe_i(rear_oe_o), .front_in_o(front_in_i),
        .rear_in_o(rear_in_i));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] be);
        for (int i = 0; i < 4; i++) if (be[i]) o[8*i+:8] = n[8*i+:8];
        return o;
    endfunction : merge
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       input logic [3:0] be = 4'hf);
        int t;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= wd;
        avs_byteenable_i <= be;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (avs_waitrequest_o !== 1'b0 && t < 50);
        q = avs_readdata_o;
        check(32'(t < 50), 32'h1);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : bus
    // One full period of the routed clock, rise to rise
    task automatic period(output int p);
        int t;
        t = 0;
        p = 0;
        while (rear_out_o.clk1 !== 1'b0 && t < 99) begin @(posedge clk_i); t++; end
        while (rear_out_o.clk1 !== 1'b1 && t < 99) begin @(posedge clk_i); t++; end
        while (rear_out_o.clk1 !== 1'b0 && t < 99) begin @(posedge clk_i); t++; p++; end
        while (rear_out_o.clk1 !== 1'b1 && t < 99) begin @(posedge clk_i); t++; p++; end
    endtask : period
    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk_i) begin
        ref_b_tick_i <= 1'($urandom);
        if (dac_pulse_o === 1'b1) n_dac++;
        if (adc_sample_o.strobe === 1'b1) n_str++;
        if (adc_sample_o.strobe === 1'b1 && adc_sample_o.adc_mask !== 4'h5) n_bad++;
        if (rear_oe_o.frame === 1'b1 && prev_f === 1'b1 && rear_out_o.frame === 1'b0) n_fall++;
        if (rear_oe_o.frame === 1'b1 && rear_out_o.frame === 1'b0) low_cnt++;
        else if (low_cnt > 0) begin
            low_len = low_cnt;
            low_cnt = 0;
        end
        prev_f <= rear_oe_o.frame & rear_out_o.frame;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h1398));
        {err_count, n_compared, n_dac, n_str, n_bad, n_fall, low_cnt, low_len} = '0;
        {reset_n_i, avs_read_i, avs_write_i, prev_f, ref_b_tick_i} = '0;
        {avs_address_i, avs_writedata_i, avs_byteenable_i} = '0;
        ref_a_tick_i = 1'b1;
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        check(32'({front_oe_o, rear_oe_o}), 32'h0);
        bus(1'b0, REG_CLK1_DIV, 32'h0);
        check(q, DIV_RESET);
        bus(1'b0, 4'hf, 32'h0);
        check(q, 32'h0);
        d = 32'($urandom_range(16'hffff, 1));
        bus(1'b1, REG_CLK2_DIV, d);
        bus(1'b1, REG_CLK2_DIV, 32'h0000_3400, 4'h2);
        bus(1'b0, REG_CLK2_DIV, 32'h0);
        check(q, merge(d, 32'h0000_3400, 4'h2));
        bus(1'b1, REG_CLK1_DIV, 32'h4);
        bus(1'b1, REG_ROUTE, 32'h41);
        bus(1'b1, REG_ADC_CFG, 32'h35);
        bus(1'b1, REG_DA_SEQ, 32'h0004_0003);
        bus(1'b1, REG_AD_SEQ, 32'h0004_0002);
        bus(1'b1, REG_GEN_ENABLE, 32'h3);
        check(32'({front_oe_o, rear_oe_o}), 32'h1);
        period(p1);
        period(p2);
        check(p1, p2);
        check(p1, 2 * 4);
        repeat (200) @(posedge clk_i);
        check(n_dac, 3);
        check(n_str, 2 * 4);
        check(n_bad, 0);
        bus(1'b1, REG_FRAME_CFG, 32'h4);
        bus(1'b1, REG_FRAME_CNT, 32'h2);
        bus(1'b1, REG_ROUTE, 32'h145);
        bus(1'b1, REG_GEN_ENABLE, 32'h5);
        repeat (400) @(posedge clk_i);
        check(n_fall, 2);
        check(low_len, p1);
        bus(1'b1, REG_DA_SEQ, 32'h0);
        bus(1'b1, REG_ROUTE, 32'ha00);
        bus(1'b1, REG_DA_SEQ, 32'h0006_0005);
        repeat (100) @(posedge clk_i);
        check(n_dac, 3 + 4);
        bus(1'b0, REG_STATUS, 32'h0);
        check(q, 32'h8);
        bus(1'b1, REG_STATUS, 32'h8);
        bus(1'b0, REG_STATUS, 32'h0);
        check(q, 32'h0);
        complete_run();
    end
endmodule : sct_timing_tb
